// ===== rtl/configurable_block_ram.v
// configurable embedded block ram, small / mid / large variants
//
// Overview of operation
// - small: 576 bits, simple dual, single, fifo, rom, shift; no true dual
// - small widths 512x1 through 32x18
// - mid: 4608 bits, true dual, simple dual, single, fifo, rom, shift
// - mid widths 4Kx1 through 128x36
// - large widths 64Kx8 through 4Kx144
// - input clear acts at once; memory output shows it next edge
// - output clear shows on the outputs at once
// - small: write enable, data, address registers share one clock
// - small: read address, read enable, output registers pick either clock
// - only the output register can be bypassed
// - mid: each port's registers may use either block clock
// - small and mid contents preloadable before running
`timescale 1ns/1ns
`include "block_ram_defines.vh"
module configurable_block_ram #(
  parameter [1:0] VARIANT = `VAR_MID,
  parameter       DW      = (VARIANT == `VAR_SMALL) ? `DW_SMALL :
                            (VARIANT == `VAR_LARGE) ? `DW_LARGE : `DW_MID,
  parameter       AD      = (VARIANT == `VAR_SMALL) ?
                            `AW_SMALL + `PX_SMALL + `PX_DATA :
                            (VARIANT == `VAR_LARGE) ?
                            `AW_LARGE + `PX_LARGE + `PX_DATA :
                            `AW_MID + `PX_MID + `PX_DATA
) (
  input  wire          clk_sys,
  input  wire          rst_n,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [7:0]    paddr,
  input  wire [31:0]   pwdata,
  output wire [31:0]   prdata,
  output wire          pready,
  output wire          pslverr,
  input  wire          blk_clk0_en,
  input  wire          blk_clk1_en,
  input  wire          clocken_a,
  input  wire          clocken_b,
  input  wire          clr_a,
  input  wire          clr_b,
  input  wire          wren_a,
  input  wire          wren_b,
  input  wire          rden_a,
  input  wire          rden_b,
  input  wire [AD-1:0] addr_a,
  input  wire [AD-1:0] addr_b,
  input  wire [DW-1:0] din_a,
  input  wire [DW-1:0] din_b,
  output wire [DW-1:0] dout_a,
  output wire [DW-1:0] dout_b,
  output wire          fifo_empty,
  output wire          fifo_full
);
  localparam SMALL = (VARIANT == `VAR_SMALL);
  localparam LARGE = (VARIANT == `VAR_LARGE);
  localparam AW = SMALL ? `AW_SMALL : LARGE ? `AW_LARGE : `AW_MID;
  localparam PX = SMALL ? `PX_SMALL : LARGE ? `PX_LARGE : `PX_MID;
  localparam [3:0] PX4 = PX;
  localparam [3:0] PD4 = `PX_DATA;
  localparam [3:0] WC_MIN = LARGE ? `WC_MIN_LARGE : `WC_MIN_SMALL;
  localparam [3:0] WC_MAX = SMALL ? `WC_MAX_SMALL :
                            LARGE ? `WC_MAX_LARGE : `WC_MAX_MID;

  // width code to exponent: 1,2,4,8,16.. or 9,18,36,72,144
  function [2:0] wexp;
    input [3:0] c;
    begin
      case (c)
        4'h0, 4'h4: wexp = 3'h0;
        4'h1, 4'h6: wexp = 3'h1;
        4'h2, 4'h8: wexp = 3'h2;
        4'h3, 4'hA: wexp = 3'h3;
        4'h5, 4'hC: wexp = 3'h4;
        4'h7:       wexp = 3'h5;
        4'h9:       wexp = 3'h6;
        default:    wexp = 3'h7;
      endcase
    end
  endfunction

  // configuration and status registers
  reg  [2:0]    mode_q;
  reg  [3:0]    wcode_q;
  reg  [3:0]    csel_q;
  reg  [1:0]    byp_q;
  reg           run_q;
  reg  [AD-1:0] tap_q;
  reg  [AD-1:0] iaddr_q;
  reg  [31:0]   ihi_q;
  reg  [DW-1:0] idat_q;
  reg           igo_q;
  reg           coll_q;
  reg  [AD-1:0] wptr_q;
  reg  [AD-1:0] rptr_q;
  reg  [AD:0]   cnt_q;
  reg           full_q;
  reg           empty_q;
  reg  [31:0]   rd_word;
  reg           addr_hit;

  wire          wr_stb;
  wire [2:0]    e = wexp(wcode_q);
  wire          par = !wcode_q[0] && wcode_q >= 4'h4;
  wire [7:0]    w = par ? (`PAR_UNIT << e) : (8'h01 << e);
  wire [3:0]    sh = par ? (PX4 - {1'b0, e}) : (PX4 + PD4 - {1'b0, e});
  wire [DW-1:0] imask = ~({DW{1'b1}} << w);
  wire [AD-1:0] slotm = ~({AD{1'b1}} << sh);
  wire [AD:0]   depth = {{AD{1'b0}}, 1'b1} << (AW + sh);
  wire [AD-1:0] pmask = depth[AD-1:0] - {{(AD-1){1'b0}}, 1'b1};

  // mode decode; true dual falls back to simple dual on the small block
  wire single = mode_q == `MODE_SINGLE;
  wire tdp    = (mode_q == `MODE_TDP) && !SMALL;
  wire sdp    = (mode_q == `MODE_SDP) || ((mode_q == `MODE_TDP) && SMALL);
  wire rom    = mode_q == `MODE_ROM;
  wire fifo   = mode_q == `MODE_FIFO;
  wire shf    = mode_q == `MODE_SHIFT;

  // block clocks arrive as enables; each register group picks one
  wire [3:0] ck;
  genvar j;
  generate
    for (j = 0; j < 4; j = j + 1) begin : g_csel
      assign ck[j] = csel_q[j] ? blk_clk1_en : blk_clk0_en;
    end
  endgenerate

  wire [1:0] ce_in;
  wire [1:0] ce_out;
  wire [1:0] wr_ok;
  wire [1:0] rd_ok;
  wire [1:0] clr = {clr_b, clr_a};
  assign ce_in[0]  = run_q & clocken_a & ck[0];
  assign ce_in[1]  = shf ? ce_in[0] : run_q & clocken_b & ck[2];
  assign ce_out[0] = clocken_a & ck[1];
  assign ce_out[1] = clocken_b & ck[3];
  assign wr_ok[0]  = wren_a & (single | sdp | tdp | shf | (fifo & ~full_q));
  assign wr_ok[1]  = wren_b & tdp;
  assign rd_ok[0]  = rden_a & (single | tdp | rom);
  assign rd_ok[1]  = shf | (rden_b & (sdp | tdp | rom | (fifo & ~empty_q)));

  // fifo and shift-register pointers in item units
  wire          push = ce_in[0] & wr_ok[0] & (fifo | shf);
  wire          pop  = ce_in[1] & rd_ok[1] & fifo;
  wire          pushf = push & fifo;
  wire [AD:0]   cnt_d = cnt_q + {{AD{1'b0}}, pushf} - {{AD{1'b0}}, pop};
  wire [AD-1:0] stap = (wptr_q - tap_q) & pmask;
  wire [AD-1:0] ea0 = (fifo | shf) ? wptr_q : addr_a;
  wire [AD-1:0] ea1 = fifo ? rptr_q : shf ? stap : addr_b;
  wire [2*AD-1:0] ea_pk  = {ea1, ea0};
  wire [2*DW-1:0] din_pk = {din_b, din_a};

  // per-port pipeline: input registers, array access, output register
  wire [1:0]      acc_w;
  wire [1:0]      we_w;
  wire [1:0]      re_w;
  wire [1:0]      clrp_w;
  wire [2*AW-1:0] word_w;
  wire [15:0]     off_w;
  wire [2*DW-1:0] din_w;
  wire [2*DW-1:0] rdw;
  wire [2*DW-1:0] dout_w;

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_port
      wire [AD-1:0]   ea   = ea_pk[i*AD +: AD];
      wire [AD-1:0]   eas  = ea >> sh;
      wire [AD+7:0]   prod = {8'h00, ea & slotm} * {{AD{1'b0}}, w};
      wire [DW-1:0]   item;
      reg             acc_q;
      reg             we_q;
      reg             re_q;
      reg             clrp_q;
      reg  [AW-1:0]   word_q;
      reg  [7:0]      off_q;
      reg  [7:0]      offp_q;
      reg  [DW-1:0]   din_q;
      reg  [DW-1:0]   dout_q;

      assign item = (rdw[i*DW +: DW] >> offp_q) & imask;

      // input registers clear at once on the port clear
      always @(posedge clk_sys or negedge rst_n or posedge clr[i]) begin
        if (!rst_n || clr[i]) begin
          acc_q  <= 1'b0;
          we_q   <= 1'b0;
          re_q   <= 1'b0;
          word_q <= {AW{1'b0}};
          off_q  <= 8'h00;
          din_q  <= {DW{1'b0}};
        end else begin
          acc_q <= ce_in[i];
          if (ce_in[i]) begin
            we_q   <= wr_ok[i];
            re_q   <= rd_ok[i];
            word_q <= eas[AW-1:0];
            off_q  <= prod[7:0];
            din_q  <= din_pk[i*DW +: DW] & imask;
          end
        end
      end

      // array read register follows the clear one edge later; zeroed in reset
      always @(posedge clk_sys or negedge rst_n or posedge clr[i]) begin
        if (!rst_n)
          clrp_q <= 1'b1;
        else if (clr[i])
          clrp_q <= 1'b1;
        else
          clrp_q <= 1'b0;
      end

      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
          offp_q <= 8'h00;
        else if (acc_q && re_q)
          offp_q <= off_q;
      end

      // output register: async clear, bypass loads every cycle
      always @(posedge clk_sys or negedge rst_n or posedge clr[i]) begin
        if (!rst_n || clr[i])
          dout_q <= {DW{1'b0}};
        else if (byp_q[i] || ce_out[i])
          dout_q <= item;
      end

      assign acc_w[i]            = acc_q;
      assign we_w[i]             = we_q;
      assign re_w[i]             = re_q;
      assign clrp_w[i]           = clrp_q;
      assign word_w[i*AW +: AW]  = word_q;
      assign off_w[i*8 +: 8]     = off_q;
      assign din_w[i*DW +: DW]   = din_q;
      assign dout_w[i*DW +: DW]  = dout_q;
    end
  endgenerate

  // preload path shares port a while the block is stopped
  wire [AD-1:0] ieas  = iaddr_q >> sh;
  wire [AD+7:0] iprod = {8'h00, iaddr_q & slotm} * {{AD{1'b0}}, w};
  wire [DW-1:0] ioff_mask = imask << iprod[7:0];
  wire [DW-1:0] mwd_a = igo_q ? (idat_q << iprod[7:0])
                              : (din_w[DW-1:0] << off_w[7:0]);
  wire [DW-1:0] mmask_a = igo_q ? ioff_mask : (imask << off_w[7:0]);
  wire [AW-1:0] maddr_a = igo_q ? ieas[AW-1:0] : word_w[AW-1:0];
  wire          mwe_a = igo_q | (acc_w[0] & we_w[0]);
  wire          mwe_b = acc_w[1] & we_w[1];
  wire [DW-1:0] rd_a;
  wire [DW-1:0] rd_b;
  assign rdw = {rd_b, rd_a};

  block_ram_array #(
    .DW (DW),
    .AW (AW)
  ) u_array (
    .clk_sys (clk_sys),
    .we_a    (mwe_a),
    .mask_a  (mmask_a),
    .addr_a  (maddr_a),
    .wd_a    (mwd_a),
    .re_a    (acc_w[0] & re_w[0]),
    .clr_a   (clrp_w[0]),
    .rd_a_q  (rd_a),
    .we_b    (mwe_b),
    .mask_b  (imask << off_w[15:8]),
    .addr_b  (word_w[2*AW-1:AW]),
    .wd_b    (din_w[2*DW-1:DW] << off_w[15:8]),
    .re_b    (acc_w[1] & re_w[1]),
    .clr_b   (clrp_w[1]),
    .rd_b_q  (rd_b)
  );

  // same word written on one port and read on the other
  wire same = word_w[AW-1:0] == word_w[2*AW-1:AW];
  wire coll_set = acc_w[0] & acc_w[1] & same &
                  ((we_w[0] & re_w[1]) | (we_w[1] & re_w[0]));

  // register decode and read mux
  always @* begin
    addr_hit = 1'b1;
    rd_word  = 32'h0000_0000;
    case (paddr)
      `REG_CTRL: begin
        rd_word[`CTRL_MODE_LSB +: 3] = mode_q;
        rd_word[`CTRL_WC_LSB +: 4]   = wcode_q;
        rd_word[`CTRL_SEL_LSB +: 4]  = csel_q;
        rd_word[`CTRL_BYP_LSB +: 2]  = byp_q;
        rd_word[`CTRL_RUN]           = run_q;
      end
      `REG_STATUS: begin
        rd_word[`ST_EMPTY]        = empty_q;
        rd_word[`ST_FULL]         = full_q;
        rd_word[`ST_COLL]         = coll_q;
        rd_word[`ST_VAR_LSB +: 2] = VARIANT;
      end
      `REG_TAP:       rd_word[AD-1:0] = tap_q;
      `REG_INIT_ADDR: rd_word[AD-1:0] = iaddr_q;
      `REG_INIT_HI:   rd_word = ihi_q;
      `REG_INIT_DATA: rd_word = 32'h0000_0000;
      default:        addr_hit = 1'b0;
    endcase
  end

  wire [2:0]     nmode = pwdata[`CTRL_MODE_LSB +: 3];
  wire [3:0]     nwc   = pwdata[`CTRL_WC_LSB +: 4];
  wire           mode_ok = (nmode <= `MODE_SHIFT) &&
                           !(SMALL && nmode == `MODE_TDP) &&
                           !(LARGE && (nmode == `MODE_ROM ||
                                       nmode == `MODE_SHIFT));
  wire           wc_ok = (nwc >= WC_MIN) && (nwc <= WC_MAX);
  wire           ctrl_wr = wr_stb && paddr == `REG_CTRL;
  wire [DW+63:0] ival = {{DW{1'b0}}, ihi_q, pwdata};
  // large block has no preload path
  wire           init_wr = wr_stb && paddr == `REG_INIT_DATA &&
                           !run_q && !LARGE;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_q  <= `MODE_SDP;
      wcode_q <= WC_MAX;
      csel_q  <= 4'h0;
      byp_q   <= 2'h0;
      run_q   <= 1'b0;
      tap_q   <= {AD{1'b0}};
      iaddr_q <= {AD{1'b0}};
      ihi_q   <= 32'h0000_0000;
      idat_q  <= {DW{1'b0}};
      igo_q   <= 1'b0;
      coll_q  <= 1'b0;
    end else begin
      igo_q <= init_wr;
      if (igo_q)
        iaddr_q <= iaddr_q + {{(AD-1){1'b0}}, 1'b1};
      if (init_wr)
        idat_q <= ival[DW-1:0] & imask;
      if (ctrl_wr) begin
        if (mode_ok)
          mode_q <= nmode;
        if (wc_ok)
          wcode_q <= nwc;
        csel_q <= pwdata[`CTRL_SEL_LSB +: 4];
        byp_q  <= pwdata[`CTRL_BYP_LSB +: 2];
        run_q  <= pwdata[`CTRL_RUN];
      end
      if (wr_stb && paddr == `REG_TAP)
        tap_q <= pwdata[AD-1:0];
      if (wr_stb && paddr == `REG_INIT_ADDR)
        iaddr_q <= pwdata[AD-1:0];
      if (wr_stb && paddr == `REG_INIT_HI)
        ihi_q <= pwdata;
      // new collisions win over a write-one clear
      coll_q <= coll_set | (coll_q & ~(wr_stb && paddr == `REG_STATUS &&
                                       pwdata[`ST_COLL]));
    end
  end

  // pointers restart whenever the layout is rewritten
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wptr_q  <= {AD{1'b0}};
      rptr_q  <= {AD{1'b0}};
      cnt_q   <= {(AD+1){1'b0}};
      full_q  <= 1'b0;
      empty_q <= 1'b1;
    end else if (ctrl_wr) begin
      wptr_q  <= {AD{1'b0}};
      rptr_q  <= {AD{1'b0}};
      cnt_q   <= {(AD+1){1'b0}};
      full_q  <= 1'b0;
      empty_q <= 1'b1;
    end else begin
      if (push)
        wptr_q <= (wptr_q + {{(AD-1){1'b0}}, 1'b1}) & pmask;
      if (pop)
        rptr_q <= (rptr_q + {{(AD-1){1'b0}}, 1'b1}) & pmask;
      cnt_q   <= cnt_d;
      full_q  <= cnt_d == depth;
      empty_q <= cnt_d == {(AD+1){1'b0}};
    end
  end

  apb_slave_port u_apb (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .addr_hit (addr_hit),
    .rd_word  (rd_word),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr),
    .wr_stb   (wr_stb)
  );

  assign dout_a     = dout_w[DW-1:0];
  assign dout_b     = dout_w[2*DW-1:DW];
  assign fifo_empty = empty_q;
  assign fifo_full  = full_q;
endmodule

// ===== rtl/block_ram_defines.vh
// register map, field positions, modes and variant constants
`ifndef BLOCK_RAM_DEFINES_VH
`define BLOCK_RAM_DEFINES_VH
`define VAR_SMALL      2'h0
`define VAR_MID        2'h1
`define VAR_LARGE      2'h2
`define DW_SMALL       18
`define DW_MID         36
`define DW_LARGE       144
`define AW_SMALL       5
`define AW_MID         7
`define AW_LARGE       12
`define PX_SMALL       1
`define PX_MID         2
`define PX_LARGE       4
`define PX_DATA        3
`define PAR_UNIT       8'h09
`define WC_MIN_SMALL   4'h0
`define WC_MAX_SMALL   4'h6
`define WC_MAX_MID     4'h8
`define WC_MIN_LARGE   4'h3
`define WC_MAX_LARGE   4'hC
`define REG_CTRL       8'h00
`define REG_STATUS     8'h04
`define REG_TAP        8'h08
`define REG_INIT_ADDR  8'h0C
`define REG_INIT_DATA  8'h10
`define REG_INIT_HI    8'h14
`define MODE_SINGLE    3'h0
`define MODE_SDP       3'h1
`define MODE_TDP       3'h2
`define MODE_ROM       3'h3
`define MODE_FIFO      3'h4
`define MODE_SHIFT     3'h5
`define CTRL_MODE_LSB  0
`define CTRL_WC_LSB    4
`define CTRL_SEL_LSB   8
`define CTRL_BYP_LSB   12
`define CTRL_RUN       14
`define ST_EMPTY       0
`define ST_FULL        1
`define ST_COLL        2
`define ST_VAR_LSB     4
`endif

// ===== rtl/block_ram_array.v
// storage array with two bit-masked write ports and registered reads
`timescale 1ns/1ns
module block_ram_array #(
  parameter DW = 36,
  parameter AW = 7
) (
  input  wire          clk_sys,
  input  wire          we_a,
  input  wire [DW-1:0] mask_a,
  input  wire [AW-1:0] addr_a,
  input  wire [DW-1:0] wd_a,
  input  wire          re_a,
  input  wire          clr_a,
  output reg  [DW-1:0] rd_a_q,
  input  wire          we_b,
  input  wire [DW-1:0] mask_b,
  input  wire [AW-1:0] addr_b,
  input  wire [DW-1:0] wd_b,
  input  wire          re_b,
  input  wire          clr_b,
  output reg  [DW-1:0] rd_b_q
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  integer      k;

  // reads sample before the write lands: mixed-port reads see old data
  always @(posedge clk_sys) begin
    for (k = 0; k < DW; k = k + 1) begin
      if (we_a && mask_a[k])
        mem[addr_a][k] <= wd_a[k];
      if (we_b && mask_b[k])
        mem[addr_b][k] <= wd_b[k];
    end
    if (clr_a)
      rd_a_q <= {DW{1'b0}};
    else if (re_a)
      rd_a_q <= mem[addr_a];
    if (clr_b)
      rd_b_q <= {DW{1'b0}};
    else if (re_b)
      rd_b_q <= mem[addr_b];
  end
endmodule

// ===== rtl/apb_slave_port.v
// apb slave handshake: zero-wait answer, read capture, error flag
`timescale 1ns/1ns
module apb_slave_port (
  input  wire        clk_sys,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire        addr_hit,
  input  wire [31:0] rd_word,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output wire        wr_stb
);
  wire setup;

  assign setup  = psel & ~penable;
  assign wr_stb = psel & penable & pready & pwrite & addr_hit;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~addr_hit;
      if (setup && !pwrite)
        prdata <= addr_hit ? rd_word : 32'h0000_0000;
    end
  end
endmodule

// ===== testbench/configurable_block_ram_assertions.sv
// port-level checks for the block ram, bound to the top module
`timescale 1ns/1ns
module configurable_block_ram_chk #(
  parameter DW = 36
) (
  input wire          clk_sys,
  input wire          rst_n,
  input wire          psel,
  input wire          penable,
  input wire          pwrite,
  input wire [31:0]   prdata,
  input wire          pready,
  input wire          pslverr,
  input wire          clr_a,
  input wire          clr_b,
  input wire [DW-1:0] dout_a,
  input wire [DW-1:0] dout_b,
  input wire          fifo_empty,
  input wire          fifo_full
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  AST_RST_OUT: assert property ($rose(rst_n) |->
    dout_a == '0 && dout_b == '0 && fifo_empty && !fifo_full)
    else $error("outputs not cleared after reset");
  AST_OUT_CLR_A: assert property (clr_a |-> dout_a == '0)
    else $error("dout_a not cleared while clr_a high");
  AST_OUT_CLR_B: assert property (clr_b |-> dout_b == '0)
    else $error("dout_b not cleared while clr_b high");
  AST_IN_CLR_B: assert property ($fell(clr_b) |=> dout_b == '0)
    else $error("dout_b not clear one edge after clr_b release");
  AST_APB_ANSWER: assert property (psel && !penable |=> pready)
    else $error("no ready in the cycle after setup");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  AST_ERR_QUAL: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  AST_PRDATA_HOLD: assert property (
    !(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data changed without a read setup");
  AST_FIFO_FLAGS: assert property (!(fifo_empty && fifo_full))
    else $error("fifo empty and full together");
endmodule

bind configurable_block_ram configurable_block_ram_chk #(.DW(DW)) chk_u (
  .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .clr_a(clr_a), .clr_b(clr_b), .dout_a(dout_a), .dout_b(dout_b),
  .fifo_empty(fifo_empty), .fifo_full(fifo_full));

// ===== testbench/fabric_user_model.sv
// fabric-side user logic driving both ports and the two block clocks
`timescale 1ns/1ns
module fabric_user_model #(
  parameter ITEM_W = 36,
  parameter ADDR_W = 12
) (
  input  wire               clk_sys,
  input  wire               slow,
  output logic              blk_clk0_en = 1'b0,
  output logic              blk_clk1_en = 1'b0,
  output logic              clocken_a = 1'b0,
  output logic              clocken_b = 1'b0,
  output logic              wren_a = 1'b0,
  output logic              wren_b = 1'b0,
  output logic              rden_a = 1'b0,
  output logic              rden_b = 1'b0,
  output logic [ADDR_W-1:0] addr_a = '0,
  output logic [ADDR_W-1:0] addr_b = '0,
  output logic [ITEM_W-1:0] din_a = '0,
  output logic [ITEM_W-1:0] din_b = '0
);
  logic [1:0] ph_q = 2'h0;

  // block clock 0 every cycle, or one in four when slow
  always @(posedge clk_sys) begin
    ph_q <= ph_q + 2'h1;
    blk_clk0_en <= !slow || ph_q == 2'h3;
    blk_clk1_en <= ph_q == 2'h1;
  end

  // index 0 is port a, index 1 port b
  task automatic req(input logic [1:0] we, input logic [1:0] re,
    input logic [ADDR_W-1:0] aa, input logic [ADDR_W-1:0] ab,
    input logic [ITEM_W-1:0] da, input logic [ITEM_W-1:0] db);
    @(posedge clk_sys);
    clocken_a <= we[0] | re[0];
    clocken_b <= we[1] | re[1];
    wren_a <= we[0];
    wren_b <= we[1];
    rden_a <= re[0];
    rden_b <= re[1];
    addr_a <= aa;
    addr_b <= ab;
    din_a <= da;
    din_b <= db;
    // held until block clock 0 takes it
    do @(posedge clk_sys); while (blk_clk0_en !== 1'b1);
    clocken_a <= 1'b0;
    clocken_b <= 1'b0;
    wren_a <= 1'b0;
    wren_b <= 1'b0;
    rden_a <= 1'b0;
    rden_b <= 1'b0;
    addr_a <= ~aa;
    addr_b <= ~ab;
    din_a <= ~da;
    din_b <= ~db;
  endtask
endmodule

// ===== testbench/configurable_block_ram_bench.sv
// self-checking bench: mid variant over apb and both user ports
`timescale 1ns/1ns
`include "block_ram_defines.vh"
module configurable_block_ram_bench;
  localparam ITEM_W = 36;
  localparam ADDR_W = 12;
  logic              clk_sys = 1'b0;
  logic              rst_n = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [7:0]        paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0;
  logic              slow = 1'b0;
  logic              clr_a = 1'b0;
  logic              clr_b = 1'b0;
  logic              hold = 1'b0;
  wire  [31:0]       prdata;
  wire               pready, pslverr, fifo_empty, fifo_full;
  wire               b0, b1, cea, ceb, wea, web, rea, reb;
  wire  [ADDR_W-1:0] aa, ab;
  wire  [ITEM_W-1:0] da, db, dout_a, dout_b;
  int                error_cnt = 0;
  int                n_compared = 0;

  configurable_block_ram #(.VARIANT(`VAR_MID)) dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .blk_clk0_en(b0), .blk_clk1_en(b1),
    .clocken_a(cea), .clocken_b(ceb), .clr_a(clr_a), .clr_b(clr_b),
    .wren_a(wea), .wren_b(web), .rden_a(rea), .rden_b(reb), .addr_a(aa),
    .addr_b(ab), .din_a(da), .din_b(db), .dout_a(dout_a), .dout_b(dout_b),
    .fifo_empty(fifo_empty), .fifo_full(fifo_full));
  fabric_user_model #(.ITEM_W(ITEM_W), .ADDR_W(ADDR_W)) fab_u (
    .clk_sys(clk_sys), .slow(slow), .blk_clk0_en(b0), .blk_clk1_en(b1),
    .clocken_a(cea), .clocken_b(ceb), .wren_a(wea), .wren_b(web),
    .rden_a(rea), .rden_b(reb), .addr_a(aa), .addr_b(ab), .din_a(da),
    .din_b(db));

  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic chk(input string what, input logic [71:0] seen,
    input logic [71:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [31:0] ctrl(input logic [2:0] m,
    input logic [3:0] w, input logic byp, input logic run);
    return {17'h0, run, byp, byp, 12'h0} | {w, 4'h0} | m;
  endfunction

  // more keeps psel up for a back-to-back setup
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    input logic more, output logic [31:0] rd, output logic err);
    if (!hold) begin
      @(posedge clk_sys);
      psel <= 1'b1;
    end
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    penable <= 1'b0;
    hold = more;
    if (!more) psel <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, 1'b0, r, e);
  endtask

  // outputs bypassed: dout is settled two edges after capture
  task automatic uread(input logic [ADDR_W-1:0] a0,
    input logic [ADDR_W-1:0] a1, output logic [ITEM_W-1:0] q0,
    output logic [ITEM_W-1:0] q1);
    fab_u.req(2'b00, 2'b11, a0, a1, 36'h0, 36'h0);
    repeat (2) @(posedge clk_sys);
    #1;
    q0 = dout_a;
    q1 = dout_b;
  endtask

  task automatic t_reset;
    logic [31:0] r;
    logic        e;
    chk("dout", {dout_a, dout_b}, 72'h0);
    chk("flags", {fifo_full, fifo_empty, pready, pslverr}, 4'h4);
    apb(1'b0, `REG_CTRL, 32'h0, 1'b1, r, e);
    chk("ctrl reset", r, ctrl(`MODE_SDP, `WC_MAX_MID, 1'b0, 1'b0));
    apb(1'b0, `REG_STATUS, 32'h0, 1'b0, r, e);
    chk("status reset", r, 32'h11);
    apb(1'b0, 8'h20, 32'h0, 1'b0, r, e);
    chk("unmapped", {e, r}, {1'b1, 32'h0});
    $display("test reset done");
  endtask

  task automatic t_modes;
    logic [31:0] r;
    logic        e;
    for (int i = 0; i < 9; i++) begin
      wr(`REG_CTRL, ctrl(i % 6, i, 1'b0, 1'b0));
      apb(1'b0, `REG_CTRL, 32'h0, 1'b0, r, e);
      chk("mode width", r, ctrl(i % 6, i, 1'b0, 1'b0));
    end
    wr(`REG_CTRL, ctrl(3'h7, 4'h9, 1'b0, 1'b0));
    apb(1'b0, `REG_CTRL, 32'h0, 1'b0, r, e);
    chk("illegal kept", r, ctrl(`MODE_TDP, `WC_MAX_MID, 1'b0, 1'b0));
    $display("test modes done");
  endtask

  task automatic t_preload;
    logic [ITEM_W-1:0] qa, qb;
    wr(`REG_CTRL, ctrl(`MODE_TDP, `WC_MAX_MID, 1'b1, 1'b0));
    wr(`REG_INIT_ADDR, 32'h5);
    wr(`REG_INIT_HI, 32'h9);
    wr(`REG_INIT_DATA, 32'h1234_5678);
    wr(`REG_INIT_HI, 32'h6);
    wr(`REG_INIT_DATA, 32'hCAFE_0001);
    // refused: not running yet
    fab_u.req(2'b01, 2'b00, 12'h5, 12'h0, 36'h0_0000_00FF, 36'h0);
    wr(`REG_CTRL, ctrl(`MODE_TDP, `WC_MAX_MID, 1'b1, 1'b1));
    uread(12'h5, 12'h6, qa, qb);
    chk("preload a", qa, 36'h9_1234_5678);
    chk("preload b", qb, 36'h6_CAFE_0001);
    $display("test preload done");
  endtask

  task automatic t_dual;
    logic [ITEM_W-1:0] qa, qb;
    @(posedge clk_sys);
    slow <= 1'b1;
    fab_u.req(2'b11, 2'b00, 12'h7, 12'h8, 36'hA_5555_0007, 36'h3_0000_AAA8);
    uread(12'h8, 12'h7, qa, qb);
    chk("cross a", qa, 36'h3_0000_AAA8);
    chk("cross b", qb, 36'hA_5555_0007);
    @(posedge clk_sys);
    slow <= 1'b0;
    $display("test dual done");
  endtask

  task automatic t_collision;
    logic [31:0]       r;
    logic              e;
    logic [ITEM_W-1:0] qa, qb;
    fab_u.req(2'b01, 2'b10, 12'h7, 12'h7, 36'hF_0F0F_0F0F, 36'h0);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("old data", dout_b, 36'hA_5555_0007);
    apb(1'b0, `REG_STATUS, 32'h0, 1'b0, r, e);
    chk("collision set", r[`ST_COLL], 1'b1);
    wr(`REG_STATUS, 32'h4);
    apb(1'b0, `REG_STATUS, 32'h0, 1'b0, r, e);
    chk("collision clear", r[`ST_COLL], 1'b0);
    uread(12'h7, 12'h7, qa, qb);
    chk("new data", qa, 36'hF_0F0F_0F0F);
    $display("test collision done");
  endtask

  task automatic t_rom_clear;
    logic [ITEM_W-1:0] qa, qb;
    wr(`REG_CTRL, ctrl(`MODE_ROM, `WC_MAX_MID, 1'b1, 1'b1));
    fab_u.req(2'b01, 2'b00, 12'h5, 12'h0, 36'h0, 36'h0);
    uread(12'h5, 12'h6, qa, qb);
    chk("rom a", qa, 36'h9_1234_5678);
    chk("rom b", qb, 36'h6_CAFE_0001);
    @(posedge clk_sys);
    clr_a <= 1'b1;
    clr_b <= 1'b1;
    #1;
    chk("clear now", {dout_a, dout_b}, 72'h0);
    repeat (2) @(posedge clk_sys);
    clr_a <= 1'b0;
    clr_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("clear kept", dout_b, 36'h0);
    uread(12'h5, 12'h6, qa, qb);
    chk("after clear", qa, 36'h9_1234_5678);
    $display("test rom clear done");
  endtask

  task automatic t_fifo;
    logic [ITEM_W-1:0] qa, qb;
    wr(`REG_CTRL, ctrl(`MODE_FIFO, `WC_MAX_MID, 1'b1, 1'b1));
    fab_u.req(2'b01, 2'b00, 12'h0, 12'h0, 36'h5_0000_0042, 36'h0);
    @(posedge clk_sys);
    #1;
    chk("fifo push", {fifo_full, fifo_empty}, 2'b00);
    uread(12'h0, 12'h0, qa, qb);
    chk("fifo pop", {qb, fifo_empty}, {36'h5_0000_0042, 1'b1});
    $display("test fifo done");
  endtask

  task automatic test_done;
    $display("compared %0d mismatched %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #200000;
    error_cnt++;
    test_done;
  end

  initial begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    t_reset;
    t_modes;
    t_preload;
    t_dual;
    t_collision;
    t_rom_clear;
    t_fifo;
    test_done;
  end
endmodule
